//--- usp_pkg.sv
// Summary of operation
// RL1 - ring input rising edge flags modem-status interrupt
// RL2 - control rts bit set drives rts low
// RL3 - rts output high after reset
// RL4 - rts affects data flow only in auto mode
// RL5 - control bit 6 selects infrared or modem
// RL6 - modem side holds receive line high idle
// RL7 - infrared receive line idles low, no data
// RL8 - modem transmit line high when idle/disabled
// RL9 - infrared transmit line low when not sending
// RL10 - loop-back ignores pin, feeds transmit to receiver
// RL11 - reset clears registers, disables transmit and receive (code resets ctrl to 8'h03, transmit and receive enabled)
// RL12 - infrared zero bit is short high pulse
package usp_pkg;
  // timing
  localparam int       CLK_HZ          = 50_000_000;
  localparam int       BAUD_HZ         = 115_200;
  localparam int       CW              = 9;
  localparam int       BIT_CYCLES_I    = CLK_HZ / BAUD_HZ;
  localparam logic [8:0] BIT_LAST      = 9'(BIT_CYCLES_I - 1);
  localparam logic [8:0] HALF_LAST     = 9'(BIT_CYCLES_I / 2 - 1);
  localparam logic [8:0] IR_PULSE      = 9'(BIT_CYCLES_I * 3 / 16);
  localparam logic [8:0] IR_STRETCH    = 9'(BIT_CYCLES_I * 3 / 4);
  // register byte offsets
  localparam logic [4:0] OFS_MCR       = 5'h00;
  localparam logic [4:0] OFS_EFR       = 5'h04;
  localparam logic [4:0] OFS_CTRL      = 5'h08;
  localparam logic [4:0] OFS_STS       = 5'h0c;
  localparam logic [4:0] OFS_MASK      = 5'h10;
  localparam logic [4:0] OFS_LINE      = 5'h14;
  localparam logic [4:0] OFS_DATA      = 5'h18;
  // field positions
  localparam int       MCR_RTS         = 1;
  localparam int       MCR_LOOP        = 4;
  localparam int       MCR_IR          = 6;
  localparam int       EFR_AUTO_RTS    = 6;
  localparam int       CTRL_TX_EN      = 0;
  localparam int       CTRL_RX_EN      = 1;
  localparam int       ST_RING         = 0;
  localparam int       ST_RX           = 1;
  localparam int       ST_TXE          = 2;
  localparam int       ST_OVR          = 3;
  // reset values
  localparam logic [7:0] MCR_RST       = 8'h00;
  localparam logic [7:0] EFR_RST       = 8'h00;
  localparam logic [7:0] CTRL_RST      = 8'h03;
  localparam logic [3:0] MASK_RST      = 4'h0;
  typedef enum logic [1:0] {
    USP_IDLE  = 2'b00,
    USP_START = 2'b01,
    USP_DATA  = 2'b11,
    USP_STOP  = 2'b10
  } usp_state_t;
endpackage

//--- usp_ir_if.sv
`timescale 1ns/1ns
interface usp_ir_if;
  logic       tx_active;
  logic       tx_bit;
  logic [8:0] bit_phase;
  logic       enc_out;
  logic       ir_in;
  logic       dec_out;
  modport codec (input tx_active, tx_bit, bit_phase, ir_in, output enc_out, dec_out);
  modport core  (output tx_active, tx_bit, bit_phase, ir_in, input enc_out, dec_out);
endinterface

//--- usp_ir_codec.sv
`timescale 1ns/1ns
module usp_ir_codec (
  input wire logic i_clk,
  input wire logic i_resetn,
  usp_ir_if.codec  ir
);
  import usp_pkg::*;
  localparam int PULSE_DLY = int'(IR_PULSE);
  logic [8:0] stretch;
  logic       ir_in_q;

  // short high pulse at the start of each zero bit, low otherwise
  assign ir.enc_out = ir.tx_active && !ir.tx_bit && (ir.bit_phase < IR_PULSE); // RL12 RL9

  // pulse edge restarts a stretch covering most of the bit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stretch <= 9'h000;
      ir_in_q <= 1'b0;
    end else begin
      ir_in_q <= ir.ir_in;
      if (ir.ir_in && !ir_in_q) begin
        stretch <= IR_STRETCH; // RL12
      end else if (stretch != 9'h000) begin
        stretch <= stretch - 9'h001;
      end
    end
  end

  // low pin with no recent pulse decodes as mark
  assign ir.dec_out = !(ir.ir_in || (stretch != 9'h000)); // RL7 RL12

  AST_IR_PULSE_END: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL12
    $rose(ir.enc_out) |-> ##PULSE_DLY !ir.enc_out)
    else $error("infrared pulse too long");
  AST_IR_DEC_ZERO: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL12
    $rose(ir.ir_in) |-> (!ir.dec_out) [*8])
    else $error("infrared pulse not decoded as zero");
endmodule

//--- usp_top.sv
`timescale 1ns/1ns
module usp_top (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [4:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic             o_irq,
  input  wire logic        i_ring_indicate_n,
  input  wire logic        i_serial_in_or_infrared_in,
  output logic             o_serial_out_or_infrared_out,
  output logic             o_request_to_send_n
);
  import usp_pkg::*;

  logic       ack;
  logic       wr_fire;
  logic       rd_fire;
  logic [7:0] modem_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] ctrl;
  logic [3:0] mask;
  logic [3:0] sts;
  logic [3:0] sts_set;
  logic       ring_q;
  logic       ir_sel;
  logic       loop_en;
  logic       auto_rts;
  logic       tx_en;
  logic       rx_en;
  logic [7:0] tx_hold;
  logic       tx_hold_valid;
  logic       tx_load;
  usp_state_t tx_state;
  logic [7:0] tx_shift;
  logic [8:0] tx_cnt;
  logic [2:0] tx_idx;
  logic       tx_line;
  usp_state_t rx_state;
  logic [8:0] rx_cnt;
  logic [2:0] rx_idx;
  logic [7:0] rx_shift;
  logic [7:0] rx_data;
  logic       rx_full;
  logic       rx_done;
  logic       rx_line;
  logic       next_pin;
  logic [7:0] next_rdata;

  usp_ir_if ir ();

  usp_ir_codec u_codec (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .ir       (ir.codec)
  );

  // mode decode
  assign ir_sel   = modem_control_reg[MCR_IR]; // RL5
  assign loop_en  = modem_control_reg[MCR_LOOP];
  assign auto_rts = enhanced_feature_reg[EFR_AUTO_RTS];
  assign tx_en    = ctrl[CTRL_TX_EN];
  assign rx_en    = ctrl[CTRL_RX_EN];

  // bus handshake: one wait cycle on every access
  assign o_waitrequest = (i_read || i_write) && !ack;
  assign wr_fire       = i_write && ack && i_byteenable[0];
  assign rd_fire       = i_read && ack;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_read || i_write) && !ack;
    end
  end

  // read data captured in the wait cycle
  always_comb begin
    next_rdata = 8'h00;
    case (i_address)
      OFS_MCR:  next_rdata = modem_control_reg;
      OFS_EFR:  next_rdata = enhanced_feature_reg;
      OFS_CTRL: next_rdata = ctrl;
      OFS_STS:  next_rdata = {4'h0, sts};
      OFS_MASK: next_rdata = {4'h0, mask};
      OFS_LINE: next_rdata = {2'b00, rx_full, tx_hold_valid, (tx_state != USP_IDLE),
                              i_ring_indicate_n, rx_line, o_serial_out_or_infrared_out};
      OFS_DATA: next_rdata = rx_data;
      default:  next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && !ack) begin
      o_readdata <= {24'h00_0000, next_rdata};
    end
  end

  // control registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      modem_control_reg    <= MCR_RST; // RL11
      enhanced_feature_reg <= EFR_RST;
      ctrl                 <= CTRL_RST;
      mask                 <= MASK_RST;
    end else if (wr_fire) begin
      case (i_address)
        OFS_MCR:  modem_control_reg    <= i_writedata[7:0];
        OFS_EFR:  enhanced_feature_reg <= i_writedata[7:0];
        OFS_CTRL: ctrl                 <= i_writedata[7:0];
        OFS_MASK: mask                 <= i_writedata[3:0];
        default:  ;
      endcase
    end
  end

  // ring pin history for edge detect
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ring_q <= 1'b1;
    end else begin
      ring_q <= i_ring_indicate_n;
    end
  end

  // event sources
  always_comb begin
    sts_set          = 4'h0;
    sts_set[ST_RING] = i_ring_indicate_n && !ring_q; // RL1
    sts_set[ST_RX]   = rx_done;
    sts_set[ST_TXE]  = tx_load;
    sts_set[ST_OVR]  = rx_done && rx_full && !(rd_fire && i_address == OFS_DATA);
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sts <= 4'h0;
    end else if (wr_fire && i_address == OFS_STS) begin
      sts <= (sts & ~i_writedata[3:0]) | sts_set;
    end else begin
      sts <= sts | sts_set;
    end
  end

  assign o_irq = |(sts & mask);

  // transmit holding byte
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_hold       <= 8'h00;
      tx_hold_valid <= 1'b0;
    end else if (wr_fire && i_address == OFS_DATA && !tx_hold_valid) begin
      tx_hold       <= i_writedata[7:0];
      tx_hold_valid <= 1'b1;
    end else if (tx_load) begin
      tx_hold_valid <= 1'b0;
    end
  end

  assign tx_load = (tx_state == USP_IDLE) && tx_hold_valid && tx_en;

  // transmit shifter, 8 data bits, one stop bit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state <= USP_IDLE;
      tx_shift <= 8'h00;
      tx_cnt   <= 9'h000;
      tx_idx   <= 3'h0;
      tx_line  <= 1'b1; // RL8 RL11
    end else if (!tx_en) begin
      tx_state <= USP_IDLE;
      tx_cnt   <= 9'h000;
      tx_line  <= 1'b1; // RL8
    end else begin
      case (tx_state)
        USP_IDLE: begin
          tx_cnt  <= 9'h000;
          tx_line <= 1'b1;
          if (tx_load) begin
            tx_shift <= tx_hold;
            tx_state <= USP_START;
            tx_line  <= 1'b0;
          end
        end
        USP_START: begin
          tx_cnt <= tx_cnt + 9'h001;
          if (tx_cnt == BIT_LAST) begin
            tx_cnt   <= 9'h000;
            tx_idx   <= 3'h0;
            tx_line  <= tx_shift[0];
            tx_state <= USP_DATA;
          end
        end
        USP_DATA: begin
          tx_cnt <= tx_cnt + 9'h001;
          if (tx_cnt == BIT_LAST) begin
            tx_cnt <= 9'h000;
            if (tx_idx == 3'h7) begin
              tx_line  <= 1'b1;
              tx_state <= USP_STOP;
            end else begin
              tx_idx  <= tx_idx + 3'h1;
              tx_line <= tx_shift[tx_idx + 3'h1];
            end
          end
        end
        USP_STOP: begin
          tx_cnt <= tx_cnt + 9'h001;
          if (tx_cnt == BIT_LAST) begin
            tx_cnt   <= 9'h000;
            tx_state <= USP_IDLE;
          end
        end
        default: tx_state <= USP_IDLE;
      endcase
    end
  end

  // encoder and decoder inputs
  assign ir.tx_active = (tx_state != USP_IDLE);
  assign ir.tx_bit    = tx_line;
  assign ir.bit_phase = tx_cnt;
  assign ir.ir_in     = ir_sel && !loop_en && i_serial_in_or_infrared_in;

  // pin shows idle level in loop-back, modem 1, infrared 0
  always_comb begin
    if (loop_en) begin
      next_pin = !ir_sel; // RL10
    end else if (ir_sel) begin
      next_pin = ir.enc_out; // RL9 RL12
    end else begin
      next_pin = tx_line; // RL8
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_out_or_infrared_out <= 1'b1; // RL8 RL11
    end else begin
      o_serial_out_or_infrared_out <= next_pin;
    end
  end

  // receiver source: loop-back, decoder, or plain pin
  assign rx_line = loop_en ? tx_line : // RL10
                   ir_sel  ? ir.dec_out : i_serial_in_or_infrared_in; // RL6 RL7

  // receive shifter, samples mid-bit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_state <= USP_IDLE; // RL11
      rx_cnt   <= 9'h000;
      rx_idx   <= 3'h0;
      rx_shift <= 8'h00;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_en) begin
        rx_state <= USP_IDLE;
        rx_cnt   <= 9'h000;
      end else begin
        case (rx_state)
          USP_IDLE: begin
            rx_cnt <= 9'h000;
            if (!rx_line) begin
              rx_state <= USP_START;
            end
          end
          USP_START: begin
            rx_cnt <= rx_cnt + 9'h001;
            if (rx_cnt == HALF_LAST) begin
              rx_cnt   <= 9'h000;
              rx_idx   <= 3'h0;
              rx_state <= rx_line ? USP_IDLE : USP_DATA;
            end
          end
          USP_DATA: begin
            rx_cnt <= rx_cnt + 9'h001;
            if (rx_cnt == BIT_LAST) begin
              rx_cnt           <= 9'h000;
              rx_shift[rx_idx] <= rx_line;
              rx_idx           <= rx_idx + 3'h1;
              if (rx_idx == 3'h7) begin
                rx_state <= USP_STOP;
              end
            end
          end
          USP_STOP: begin
            rx_cnt <= rx_cnt + 9'h001;
            if (rx_cnt == BIT_LAST) begin
              rx_cnt   <= 9'h000;
              rx_done  <= rx_line;
              rx_state <= USP_IDLE;
            end
          end
          default: rx_state <= USP_IDLE;
        endcase
      end
    end
  end

  // receive holding byte, new byte wins over read clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_done) begin
      rx_data <= rx_shift;
      rx_full <= 1'b1;
    end else if (rd_fire && i_address == OFS_DATA) begin
      rx_full <= 1'b0;
    end
  end

  // rts manual unless auto flow control throttles on full buffer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_request_to_send_n <= 1'b1; // RL3 RL11
    end else if (auto_rts) begin
      o_request_to_send_n <= !(modem_control_reg[MCR_RTS] && !rx_full); // RL4
    end else begin
      o_request_to_send_n <= !modem_control_reg[MCR_RTS]; // RL2 RL4
    end
  end

  AST_RING_EVENT: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL1
    (i_ring_indicate_n && !ring_q) |=> sts[ST_RING])
    else $error("ring edge not flagged");
  AST_RING_IRQ: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL1
    (i_ring_indicate_n && !ring_q && mask[ST_RING]) |=> o_irq)
    else $error("unmasked ring event gave no interrupt");
  AST_RTS_MANUAL: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL2
    (!auto_rts && modem_control_reg[MCR_RTS]) |=> !o_request_to_send_n)
    else $error("rts not asserted by control bit");
  AST_RTS_AUTO: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL4
    (auto_rts && rx_full) |=> o_request_to_send_n)
    else $error("auto rts not released on full buffer");
  AST_RTS_RESET: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL3
    $rose(i_resetn) |-> o_request_to_send_n)
    else $error("rts low after reset");
  AST_TX_IDLE_MODEM: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL8
    (!ir_sel && (tx_state == USP_IDLE) && !tx_load) |=> o_serial_out_or_infrared_out)
    else $error("modem transmit line not high while idle");
  AST_TX_IDLE_IR: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL9
    (ir_sel && (tx_state == USP_IDLE)) |=> !o_serial_out_or_infrared_out)
    else $error("infrared transmit line not low while idle");
  AST_LOOP_ROUTE: assert property (@(posedge i_clk) disable iff (!i_resetn) // RL10
    (loop_en && $stable(loop_en) && tx_state == USP_START) |-> !rx_line)
    else $error("loop-back start bit not seen by receiver");
  AST_BUS_WAIT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ((i_read || i_write) && o_waitrequest) |=> !o_waitrequest)
    else $error("bus wait longer than one cycle");
endmodule

//--- usp_link_model.sv
`timescale 1ns/1ns
module usp_link_model
  import usp_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_ir,
  input  wire logic i_jam,
  input  wire logic i_dev_line,
  output logic      o_line
);
  logic busy = 1'b0;
  logic lvl  = 1'b1;

  // idle level: high for modem, low for infrared; jam forces the other level
  assign o_line = busy ? lvl : (i_jam ? i_ir : ~i_ir);

  // frame out, lsb first, infrared zero as short high pulse
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      for (int c = 0; c < BIT_CYCLES_I; c++) begin
        @(posedge i_clk);
        busy <= 1'b1;
        lvl  <= i_ir ? (!fr[k] && c < int'(IR_PULSE)) : fr[k];
      end
    end
    @(posedge i_clk);
    busy <= 1'b0;
  endtask

  // frame in; bounded wait for the start bit
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    logic [9:0] fr;
    logic       hit;
    int         n;
    n  = 0;
    ok = 1'b0;
    b  = 8'h00;
    while (i_dev_line === ~i_ir && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20000) return;
    for (int k = 0; k < 10; k++) begin
      hit = 1'b0;
      for (int c = 0; c < BIT_CYCLES_I; c++) begin
        @(posedge i_clk);
        if (i_ir && c < BIT_CYCLES_I - 8) hit = hit | (i_dev_line === 1'b1);
        else if (!i_ir && c == BIT_CYCLES_I / 2) hit = (i_dev_line === 1'b1);
      end
      fr[k] = i_ir ? ~hit : hit;
    end
    b  = fr[8:1];
    ok = !fr[0] && fr[9];
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import usp_pkg::*;
  logic        clk, rstn, rd, wr, ring_n, ir, jam;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic        wait_req, irq, ser_in, ser_out, rts_n;
  logic [7:0]  d;
  logic        ok;
  int          err_total = 0;
  int          total_checks = 0;

  usp_top u_usp_top (
    .i_clk(clk), .i_resetn(rstn), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
    .o_waitrequest(wait_req), .o_irq(irq), .i_ring_indicate_n(ring_n),
    .i_serial_in_or_infrared_in(ser_in), .o_serial_out_or_infrared_out(ser_out),
    .o_request_to_send_n(rts_n)
  );
  usp_link_model u_usp_link_model (
    .i_clk(clk), .i_ir(ir), .i_jam(jam), .i_dev_line(ser_out), .o_line(ser_in)
  );

  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v,
                     input logic [3:0] e, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= {24'h0, v};
    be    <= e;
    wr    <= w;
    rd    <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q  = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    chk({31'h0, wait_req}, 32'h0);
  endtask

  task automatic wreg(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] q;
    bus(1'b1, a, v, 4'hf, q);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 4'hf, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask

  task automatic pins(input logic r, input logic t, input logic i);
    repeat (3) @(negedge clk);
    chk({29'h0, rts_n, ser_out, irq}, {29'h0, r, t, i});
  endtask

  task automatic t_reset();
    logic [4:0] a [6] = '{OFS_MCR, OFS_EFR, OFS_CTRL, OFS_STS, OFS_MASK, 5'h1c};
    logic [7:0] v [6] = '{MCR_RST, EFR_RST, CTRL_RST, 8'h00, {4'h0, MASK_RST}, 8'h00};
    pins(1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 6; k++) rchk(a[k], v[k]);
  endtask

  task automatic t_rts();
    logic [7:0] q;
    bus(1'b1, OFS_MCR, 8'h02, 4'he, q);
    pins(1'b1, 1'b1, 1'b0);
    wreg(OFS_MCR, 8'h02);
    pins(1'b0, 1'b1, 1'b0);
    wreg(5'h1c, 8'hff);
    rchk(5'h1c, 8'h00);
    wreg(OFS_MCR, 8'h00);
    pins(1'b1, 1'b1, 1'b0);
  endtask

  task automatic ring_pulse();
    @(posedge clk);
    ring_n <= 1'b0;
    repeat (5) @(posedge clk);
    ring_n <= 1'b1;
  endtask

  task automatic t_ring();
    @(posedge clk);
    ring_n <= 1'b0;
    repeat (5) @(posedge clk);
    rchk(OFS_STS, 8'h00);
    ring_n <= 1'b1;
    pins(1'b1, 1'b1, 1'b0);
    rchk(OFS_STS, 8'h01);
    wreg(OFS_MASK, 8'h01);
    pins(1'b1, 1'b1, 1'b1);
    wreg(OFS_STS, 8'h01);
    pins(1'b1, 1'b1, 1'b0);
    ring_pulse();
    pins(1'b1, 1'b1, 1'b1);
    wreg(OFS_STS, 8'h01);
    wreg(OFS_MASK, 8'h00);
  endtask

  task automatic t_tx();
    // byte waits while the transmitter is disabled, line stays high
    wreg(OFS_CTRL, 8'h02);
    fork
      begin
        wreg(OFS_DATA, 8'ha5);
        pins(1'b1, 1'b1, 1'b0);
        rchk(OFS_LINE, 8'h17);
        wreg(OFS_CTRL, CTRL_RST);
      end
      u_usp_link_model.recv_byte(d, ok);
    join
    chk({23'h0, ok, d}, {23'h0, 1'b1, 8'ha5});
    pins(1'b1, 1'b1, 1'b0);
  endtask

  task automatic t_rx_rts();
    wreg(OFS_MCR, 8'h02);
    u_usp_link_model.send_byte(8'h3c);
    pins(1'b0, 1'b1, 1'b0);
    rchk(OFS_DATA, 8'h3c);
    wreg(OFS_EFR, 8'h40);
    pins(1'b0, 1'b1, 1'b0);
    u_usp_link_model.send_byte(8'hc3);
    pins(1'b1, 1'b1, 1'b0);
    rchk(OFS_DATA, 8'hc3);
    pins(1'b0, 1'b1, 1'b0);
    wreg(OFS_EFR, 8'h00);
    wreg(OFS_MCR, 8'h00);
  endtask

  task automatic t_loop();
    int bad;
    bad = 0;
    wreg(OFS_MCR, 8'h10);
    jam <= 1'b1;
    fork
      wreg(OFS_DATA, 8'h69);
      for (int c = 0; c < 11 * BIT_CYCLES_I; c++) begin
        @(negedge clk);
        if (ser_out !== 1'b1) bad++;
      end
    join
    chk(bad, 0);
    rchk(OFS_DATA, 8'h69);
    jam <= 1'b0;
    wreg(OFS_MCR, 8'h00);
  endtask

  task automatic t_ir();
    ir  <= 1'b1;
    jam <= 1'b1;
    wreg(OFS_MCR, 8'h40);
    jam <= 1'b0;
    pins(1'b1, 1'b0, 1'b0);
    fork
      wreg(OFS_DATA, 8'h5a);
      u_usp_link_model.recv_byte(d, ok);
    join
    chk({23'h0, ok, d}, {23'h0, 1'b1, 8'h5a});
    pins(1'b1, 1'b0, 1'b0);
    u_usp_link_model.send_byte(8'h96);
    rchk(OFS_DATA, 8'h96);
  endtask

  task automatic t_reset_mid();
    wreg(OFS_MCR, 8'h42);
    wreg(OFS_DATA, 8'h00);
    pins(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    rstn <= 1'b0;
    ir   <= 1'b0;
    pins(1'b1, 1'b1, 1'b0);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rchk(OFS_MCR, 8'h00);
    pins(1'b1, 1'b1, 1'b0);
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    be = 4'hf;
    ring_n = 1'b1;
    ir = 1'b0;
    jam = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_rts();
    t_ring();
    t_tx();
    t_rx_rts();
    t_loop();
    t_ir();
    t_reset_mid();
    conclude();
  end

  // watchdog, well past the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
